// ### hw/sebus_pkg.sv
// shared constants and types of the two-wire serial eeprom target
package sebus_pkg;

  // device address word prefixes
  localparam logic [3:0] SEBUS_PREFIX_ARRAY = 4'hA;
  localparam logic [3:0] SEBUS_PREFIX_SERIAL = 4'hB;
  // serial block word address prefix expected from the controller
  localparam logic [1:0] SEBUS_SN_WADR_PREFIX = 2'h2;

  // array organisation
  localparam int SEBUS_PAGE_BYTES = 16;
  localparam int SEBUS_SMALL_PAGES = 32;
  localparam int SEBUS_LARGE_PAGES = 64;
  localparam int SEBUS_SMALL_AW = 9;
  localparam int SEBUS_LARGE_AW = 10;
  localparam int SEBUS_WORD_BITS = 8;
  localparam int SEBUS_SN_BITS = 128;

  // timing
  localparam int unsigned SEBUS_CLK_HZ = 50_000_000;
  localparam int unsigned SEBUS_SELF_TIMED_WRITE_DURATION_MS = 5;
  localparam int unsigned SEBUS_WR_CYCLES =
    SEBUS_SELF_TIMED_WRITE_DURATION_MS * (SEBUS_CLK_HZ / 1000);

  // reset values and bit counter limits
  localparam logic [3:0] SEBUS_SYNC_RST = 4'hC;
  localparam logic [3:0] SEBUS_BITCNT_RST = 4'h0;
  localparam logic [7:0] SEBUS_BYTE_RST = 8'h00;
  localparam logic [3:0] SEBUS_BITCNT_FULL = 4'h8;
  localparam logic [3:0] SEBUS_BITCNT_LAST = 4'h7;

  typedef enum logic [2:0] {
    SEBUS_ST_IDLE,
    SEBUS_ST_RX,
    SEBUS_ST_ACK,
    SEBUS_ST_TX,
    SEBUS_ST_MACK
  } sebus_state_e;

  typedef enum logic [1:0] {
    SEBUS_K_DEV,
    SEBUS_K_WADR,
    SEBUS_K_DATA
  } sebus_kind_e;

  // device address word as received
  typedef struct packed {
    logic [3:0] prefix;
    logic chip_select_strap_high;
    logic mid_sel;
    logic page_select_bit0;
    logic rw;
  } sebus_dev_word_s;

  // status seen by the surrounding logic
  typedef struct packed {
    logic standby;
    logic write_busy;
    logic addressed;
    logic serial_sel;
  } sebus_status_s;

endpackage

// ### hw/sebus_target.sv
// two-wire serial eeprom target with serial number block
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - small variant: 32 pages of 16 bytes, 9-bit word address
// - large variant: 64 pages of 16 bytes, 10-bit word address
// - self-timed write after a write Stop lasts at most 5 ms
// - data changes only while clock low; high-clock changes are Start/Stop
// - data falling while clock high is Start; every command starts so
// - data rising while clock high is Stop, ending a transaction
// - Stop after a read returns the target to idle
// - 8-bit words, target pulls data low in ninth clock as acknowledge
// - idle at power-up and after Stop once pending write completes
// - address word follows each Start; array prefix is 1010
// - small: bits 3,2 match both straps, bit 1 is top address bit
// - large: bit 3 matches strap, bits 2,1 are top address bits
// - address bit 0 chooses direction: one read, zero write
// - match gives acknowledge; mismatch gives none and returns idle
// - prefix 1011 selects the 128-bit serial number block
// - serial access matches straps; bit 1 (and large bit 2) zero
// - serial prefix with write direction only loads the pointer
// - serial number is read-only; no sequence alters it
// - input sampled on clock rise, output shifted after clock fall
// - during self-timed write inputs ignored, no acknowledge given
// - page write advances only low four address bits, wrapping in page
module sebus_target
  import sebus_pkg::*;
#(
  parameter bit LARGE = 1'b0,
  parameter int unsigned WR_CYCLES = SEBUS_WR_CYCLES,
  // arbitrary serial value
  parameter logic [127:0] SERIAL_VALUE = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // straps
  input wire logic chip_select_strap_high,
  input wire logic chip_select_strap_low,
  // status
  output var sebus_pkg::sebus_status_s status
);
  import sebus_pkg::*;

  localparam int AW = LARGE ? SEBUS_LARGE_AW : SEBUS_SMALL_AW;
  localparam int PAGES = LARGE ? SEBUS_LARGE_PAGES : SEBUS_SMALL_PAGES;
  localparam int DEPTH = PAGES * SEBUS_PAGE_BYTES;
  localparam int CW = $clog2(WR_CYCLES + 1);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // input synchronisers: scl, sda, strap high, strap low
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [1:0] line_d_r;
  wire logic [3:0] pins_raw = {scl_i, sda_i, chip_select_strap_high, chip_select_strap_low};

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_r <= SEBUS_SYNC_RST;
      sync2_r <= SEBUS_SYNC_RST;
      line_d_r <= SEBUS_SYNC_RST[3:2];
    end else if (clk_en) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      line_d_r <= sync2_r[3:2];
    end
  end

  wire logic scl_s = sync2_r[3];
  wire logic sda_s = sync2_r[2];
  wire logic cs_hi_s = sync2_r[1];
  wire logic cs_lo_s = sync2_r[0];
  wire logic scl_d = line_d_r[1];
  wire logic sda_d = line_d_r[0];

  // line events
  wire logic scl_rise = scl_s & ~scl_d;
  wire logic scl_fall = ~scl_s & scl_d;
  wire logic start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire logic stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // state
  sebus_state_e state_r, state_nxt;
  sebus_kind_e kind_r, kind_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic oe_r, oe_nxt;
  logic [AW-1:0] ptr_r, ptr_nxt;
  logic [1:0] page_r, page_nxt;
  logic sn_r, sn_nxt;
  logic rw_r, rw_nxt;
  logic mack_r, mack_nxt;
  logic pend_r, pend_nxt;
  logic busy_r;
  logic [CW-1:0] wr_cnt_r;
  logic mem_we;
  sebus_status_s status_nxt;

  // memory
  logic [7:0] mem [DEPTH];

  // device address decode
  wire sebus_dev_word_s dw = rx_sh_r;
  wire logic pfx_arr = dw.prefix == SEBUS_PREFIX_ARRAY;
  wire logic pfx_sn = dw.prefix == SEBUS_PREFIX_SERIAL;
  wire logic cs_hi_ok = dw.chip_select_strap_high == cs_hi_s;
  wire logic cs_lo_ok = LARGE || (dw.mid_sel == cs_lo_s);
  wire logic sn_fix_ok = !dw.page_select_bit0 && (!LARGE || !dw.mid_sel);
  wire logic dev_match = cs_hi_ok && cs_lo_ok && (pfx_arr || (pfx_sn && sn_fix_ok));
  wire logic [1:0] dev_page = LARGE ? {dw.mid_sel, dw.page_select_bit0}
                                    : {1'b0, dw.page_select_bit0};

  // pointer arithmetic
  wire logic [9:0] wadr_full = {page_r, rx_sh_r};
  wire logic [AW-1:0] wadr = wadr_full[AW-1:0];
  wire logic [AW-1:0] ptr_inc_page = {ptr_r[AW-1:4], ptr_r[3:0] + 4'h1};
  wire logic [AW-1:0] ptr_inc_read = sn_r ? ptr_inc_page : ptr_r + 1'b1;
  wire logic [6:0] sn_top = {~ptr_r[3:0], 3'h7};
  wire logic [7:0] sn_byte = SERIAL_VALUE[sn_top -: 8];
  wire logic [7:0] rd_byte = sn_r ? sn_byte : mem[ptr_r];
  wire logic rx_full = bit_cnt_r == SEBUS_BITCNT_FULL;
  wire logic busy_start = !busy_r && stop_det && pend_r;

  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    bit_cnt_nxt = bit_cnt_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    oe_nxt = oe_r;
    ptr_nxt = ptr_r;
    page_nxt = page_r;
    sn_nxt = sn_r;
    rw_nxt = rw_r;
    mack_nxt = mack_r;
    pend_nxt = pend_r;
    mem_we = 1'b0;
    if (busy_r) begin
      // inputs ignored while the write cycle runs
      state_nxt = SEBUS_ST_IDLE;
      oe_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = SEBUS_ST_IDLE;
      oe_nxt = 1'b0;
      pend_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = SEBUS_ST_RX;
      kind_nxt = SEBUS_K_DEV;
      bit_cnt_nxt = SEBUS_BITCNT_RST;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        SEBUS_ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        SEBUS_ST_RX: begin
          if (scl_rise && !rx_full) begin
            rx_sh_nxt = {rx_sh_r[6:0], sda_s};
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end else if (scl_fall && rx_full) begin
            if (kind_r == SEBUS_K_DEV && !dev_match) begin
              state_nxt = SEBUS_ST_IDLE;
            end else begin
              state_nxt = SEBUS_ST_ACK;
              oe_nxt = 1'b1;
              unique case (kind_r)
                SEBUS_K_DEV: begin
                  rw_nxt = dw.rw;
                  sn_nxt = pfx_sn;
                  page_nxt = dev_page;
                end
                SEBUS_K_WADR: begin
                  ptr_nxt = wadr;
                end
                SEBUS_K_DATA: begin
                  mem_we = !sn_r;
                  pend_nxt = pend_r || !sn_r;
                  ptr_nxt = ptr_inc_page;
                end
                default: begin
                  state_nxt = SEBUS_ST_IDLE;
                end
              endcase
            end
          end
        end
        SEBUS_ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt = SEBUS_BITCNT_RST;
            if (kind_r == SEBUS_K_DEV && rw_r) begin
              state_nxt = SEBUS_ST_TX;
              tx_sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              ptr_nxt = ptr_inc_read;
            end else begin
              state_nxt = SEBUS_ST_RX;
              oe_nxt = 1'b0;
              kind_nxt = (kind_r == SEBUS_K_DEV) ? SEBUS_K_WADR : SEBUS_K_DATA;
            end
          end
        end
        SEBUS_ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == SEBUS_BITCNT_LAST) begin
              state_nxt = SEBUS_ST_MACK;
              oe_nxt = 1'b0;
              bit_cnt_nxt = SEBUS_BITCNT_RST;
            end else begin
              tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
              oe_nxt = ~tx_sh_r[6];
              bit_cnt_nxt = bit_cnt_r + 4'h1;
            end
          end
        end
        SEBUS_ST_MACK: begin
          if (scl_rise) begin
            mack_nxt = sda_s;
          end else if (scl_fall) begin
            if (!mack_r) begin
              state_nxt = SEBUS_ST_TX;
              tx_sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              ptr_nxt = ptr_inc_read;
            end else begin
              state_nxt = SEBUS_ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = SEBUS_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= SEBUS_ST_IDLE;
      kind_r <= SEBUS_K_DEV;
      bit_cnt_r <= SEBUS_BITCNT_RST;
      rx_sh_r <= SEBUS_BYTE_RST;
      tx_sh_r <= SEBUS_BYTE_RST;
      oe_r <= 1'b0;
      ptr_r <= '0;
      page_r <= 2'h0;
      sn_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b1;
      pend_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
      oe_r <= oe_nxt;
      ptr_r <= ptr_nxt;
      page_r <= page_nxt;
      sn_r <= sn_nxt;
      rw_r <= rw_nxt;
      mack_r <= mack_nxt;
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && mem_we) begin
      mem[ptr_r] <= rx_sh_r;
    end
  end

  // self-timed write cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      wr_cnt_r <= '0;
    end else if (clk_en) begin
      if (busy_start) begin
        busy_r <= 1'b1;
        wr_cnt_r <= '0;
      end else if (busy_r && wr_cnt_r == CW'(WR_CYCLES - 1)) begin
        busy_r <= 1'b0;
      end else if (busy_r) begin
        wr_cnt_r <= wr_cnt_r + 1'b1;
      end
    end
  end

  assign status_nxt = '{
    standby: (state_r == SEBUS_ST_IDLE) && !busy_r,
    write_busy: busy_r,
    addressed: state_r != SEBUS_ST_IDLE,
    serial_sel: sn_r
  };

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      status <= '0;
    end else if (clk_en) begin
      status <= status_nxt;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;

  // checks
  sequence byte_taken;
    clk_en && state_r == SEBUS_ST_RX && rx_full && scl_fall && !busy_r;
  endsequence

  sequence dev_byte;
    byte_taken ##0 (kind_r == SEBUS_K_DEV);
  endsequence

  dev_ack_drive_a: assert property (dev_byte ##0 dev_match |=> oe_r && state_r == SEBUS_ST_ACK)
    else $error("matching address not acknowledged");
  dev_mismatch_a: assert property (dev_byte ##0 !dev_match |=> !oe_r && state_r == SEBUS_ST_IDLE)
    else $error("mismatching address not released");
  idle_release_a: assert property (state_r == SEBUS_ST_IDLE |-> !oe_r)
    else $error("data driven while idle");
  start_detect_a: assert property (clk_en && start_det && !busy_r |=>
      state_r == SEBUS_ST_RX && kind_r == SEBUS_K_DEV && bit_cnt_r == 4'h0)
    else $error("start not taken");
  stop_idle_a: assert property (clk_en && stop_det |=> state_r == SEBUS_ST_IDLE)
    else $error("stop did not return to idle");
  busy_silent_a: assert property (busy_r |-> !oe_r && state_r == SEBUS_ST_IDLE)
    else $error("activity during write cycle");
  write_len_a: assert property ($fell(busy_r) |-> $past(wr_cnt_r) == CW'(WR_CYCLES - 1))
    else $error("write cycle length wrong");
  page_wrap_a: assert property (byte_taken ##0 kind_r == SEBUS_K_DATA |=>
      ptr_r[AW-1:4] == $past(ptr_r[AW-1:4]))
    else $error("page bits moved during write");
  serial_ro_a: assert property (byte_taken ##0 sn_r |-> !mem_we ##1 $stable(pend_r))
    else $error("serial mode wrote array");
  serial_sel_a: assert property (dev_byte ##0 (dev_match && pfx_sn) |=> sn_r)
    else $error("serial block not selected");
  rise_sample_a: assert property (clk_en && state_r == SEBUS_ST_RX && scl_rise &&
      !rx_full |=> rx_sh_r[0] == $past(sda_s))
    else $error("data not sampled on rise");
  drive_low_clk_a: assert property ($rose(oe_r) |-> !$past(scl_s))
    else $error("drive started with clock high");

endmodule
`default_nettype wire

// ### tb/sebus_ctrl_model.sv
// two-wire bus controller model driving clock and data
`timescale 1ns/1ps
`default_nettype none
module sebus_ctrl_model (
  // clock
  input wire logic clk_sys,
  // bus
  input wire logic sda_w,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask
  // data pulled while clock high
  task automatic start();
    sda_pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b1;
    half();
    scl = 1'b0;
  endtask
  // data released while clock high
  task automatic stop();
    @(negedge clk_sys);
    sda_pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_pull = 1'b0;
    half();
  endtask
  // data set only in clock low, sampled late in clock high
  task automatic xfer(input logic b, output logic r);
    @(negedge clk_sys);
    sda_pull = ~b;
    repeat (3) @(negedge clk_sys);
    scl = 1'b1;
    half();
    r = sda_w;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xfer(d[i], r);
    xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, r);
      d[i] = r;
    end
    xfer(last, r);
  endtask
  // bus recovery sequence
  task automatic recover();
    logic r;
    start();
    repeat (9) xfer(1'b1, r);
    start();
    stop();
  endtask
endmodule
`default_nettype wire

// ### tb/sebus_target_test.sv
// self-checking bench of the two-wire serial eeprom target
`timescale 1ns/1ps
`default_nettype none
module sebus_target_test;
  import sebus_pkg::*;
  localparam logic [127:0] SN = 128'h5A3C_9E01_7B24_D6F8_0C13_A5E7_4B92_6D08;
  localparam int unsigned WRC = 400;
  localparam logic [3:0] PA = SEBUS_PREFIX_ARRAY;
  localparam logic [3:0] PB = SEBUS_PREFIX_SERIAL;
  logic clk_sys, resetn, clk_en, scl, sda_pull, sda_o, sda_oe, sh, sl;
  logic scl_l, sda_pull_l, sda_o_l, sda_oe_l, shl;
  wire logic sda_w;
  wire logic sda_w_l;
  sebus_status_s status;
  sebus_status_s status_l;
  int n_errors, n_tests;
  logic [7:0] mem [512];
  assign sda_w = ~(sda_pull | (sda_oe & ~sda_o));
  assign sda_w_l = ~(sda_pull_l | (sda_oe_l & ~sda_o_l));
  sebus_target #(.LARGE(1'b0), .WR_CYCLES(WRC), .SERIAL_VALUE(SN)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_strap_high(sh),
    .chip_select_strap_low(sl), .status(status));
  sebus_ctrl_model i_ctrl (.clk_sys(clk_sys), .sda_w(sda_w), .scl(scl), .sda_pull(sda_pull));
  sebus_target #(.LARGE(1'b1), .WR_CYCLES(WRC), .SERIAL_VALUE(SN)) i_dut_large (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .scl_i(scl_l), .sda_i(sda_w_l),
    .sda_o(sda_o_l), .sda_oe(sda_oe_l), .chip_select_strap_high(shl),
    .chip_select_strap_low(sl), .status(status_l));
  sebus_ctrl_model i_ctrl_l (.clk_sys(clk_sys), .sda_w(sda_w_l), .scl(scl_l),
    .sda_pull(sda_pull_l));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] dev(input logic [3:0] p, input logic pg, input logic rw);
    return {p, sh, sl, pg, rw};
  endfunction
  function automatic logic [7:0] sn_byte(input int i);
    return SN[127 - 8 * (i % 16) -: 8];
  endfunction
  task automatic poll(output int n);
    logic a;
    n = 0;
    a = 1'b0;
    while (!a && n < 20) begin
      n++;
      i_ctrl.start();
      i_ctrl.wbyte(dev(PA, 1'b0, 1'b0), a);
    end
    i_ctrl.stop();
  endtask
  task automatic serial_read();
    logic a;
    logic [7:0] d;
    i_ctrl.start();
    i_ctrl.wbyte(dev(PB, 1'b0, 1'b0), a);
    chk("sn_adr_ack", 8'(a), 8'h01);
    i_ctrl.wbyte({SEBUS_SN_WADR_PREFIX, 6'h00}, a);
    i_ctrl.start();
    i_ctrl.wbyte(dev(PB, 1'b0, 1'b1), a);
    chk("sn_rd_ack", 8'(a), 8'h01);
    chk("sn_status", {4'h0, status}, 8'h03);
    for (int i = 0; i < 17; i++) begin
      i_ctrl.rbyte(i == 16, d);
      chk("sn_byte", d, sn_byte(i));
    end
    i_ctrl.stop();
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  initial begin
    logic a;
    logic [7:0] d;
    logic [8:0] ad;
    logic [7:0] bad [5];
    logic [9:0] al, am;
    logic [7:0] dl [2];
    int n;
    n = $urandom(32'h8305df36);
    clk_en = 1'b1;
    resetn = 1'b0;
    sh = 1'($urandom);
    sl = 1'($urandom);
    shl = 1'($urandom);
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("status_idle", {status, status_l}, 8'h88);
    chk("open_drain", 8'({sda_o, sda_o_l}), 8'h00);
    for (int k = 0; k < 2; k++) begin
      ad = {k[0], 8'($urandom)};
      i_ctrl.start();
      i_ctrl.wbyte(dev(PA, ad[8], 1'b0), a);
      chk("dev_ack", 8'(a), 8'h01);
      i_ctrl.wbyte(ad[7:0], a);
      for (int j = 0; j < 17; j++) begin
        d = 8'($urandom);
        mem[{ad[8:4], 4'(ad[3:0] + j)}] = d;
        i_ctrl.wbyte(d, a);
        chk("data_ack", 8'(a), 8'h01);
      end
      i_ctrl.stop();
      repeat (8) @(negedge clk_sys);
      chk("busy", 8'(status.write_busy), 8'h01);
      if (k == 0) begin
        clk_en = 1'b0;
        repeat (WRC + 50) @(negedge clk_sys);
        clk_en = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk("frozen_busy", 8'(status.write_busy), 8'h01);
      end
      poll(n);
      chk("poll_nack", 8'(n > 1), 8'h01);
      chk("poll_bound", 8'(n < 8), 8'h01);
      i_ctrl.start();
      i_ctrl.wbyte(dev(PA, ad[8], 1'b0), a);
      i_ctrl.wbyte({ad[7:4], 4'h0}, a);
      i_ctrl.start();
      i_ctrl.wbyte(dev(PA, ad[8], 1'b1), a);
      chk("rd_ack", 8'(a), 8'h01);
      for (int j = 0; j < 16; j++) begin
        i_ctrl.rbyte(j == 15, d);
        chk("rd_byte", d, mem[{ad[8:4], 4'(j)}]);
      end
      i_ctrl.stop();
      repeat (8) @(negedge clk_sys);
      chk("standby", {4'h0, status}, 8'h08);
    end
    bad = '{dev(4'h9, 1'b0, 1'b0), {PA, ~sh, sl, 2'b00}, {PA, sh, ~sl, 2'b01},
      {PB, sh, sl, 2'b11}, {PB, ~sh, sl, 2'b01}};
    for (int i = 0; i < 5; i++) begin
      i_ctrl.start();
      i_ctrl.wbyte(bad[i], a);
      chk("bad_nack", 8'(a), 8'h00);
      i_ctrl.wbyte(8'($urandom), a);
      chk("ignored", 8'(a), 8'h00);
      i_ctrl.stop();
    end
    serial_read();
    i_ctrl.start();
    i_ctrl.wbyte(dev(PB, 1'b0, 1'b0), a);
    i_ctrl.wbyte(8'h80, a);
    i_ctrl.wbyte(~sn_byte(0), a);
    i_ctrl.stop();
    poll(n);
    serial_read();
    i_ctrl.start();
    i_ctrl.wbyte(dev(PA, ad[8], 1'b0), a);
    repeat (3) i_ctrl.xfer(1'b0, a);
    i_ctrl.recover();
    i_ctrl.start();
    i_ctrl.wbyte(dev(PA, ad[8], 1'b0), a);
    i_ctrl.wbyte(ad[7:0], a);
    i_ctrl.start();
    i_ctrl.wbyte(dev(PA, ad[8], 1'b1), a);
    chk("recover_ack", 8'(a), 8'h01);
    i_ctrl.rbyte(1'b1, d);
    chk("recover_rd", d, mem[ad]);
    i_ctrl.stop();
    al = 10'($urandom);
    for (int m = 0; m < 4; m++) begin
      am = al ^ {m[0], 9'h000};
      i_ctrl_l.start();
      i_ctrl_l.wbyte({PA, shl, am[9:8], 1'b0}, a);
      chk("large_ack", 8'(a), 8'h01);
      i_ctrl_l.wbyte(am[7:0], a);
      if (m < 2) begin
        dl[m] = 8'($urandom);
        i_ctrl_l.wbyte(dl[m], a);
        i_ctrl_l.stop();
        repeat (WRC + 20) @(negedge clk_sys);
      end else begin
        i_ctrl_l.start();
        i_ctrl_l.wbyte({PA, shl, am[9:8], 1'b1}, a);
        i_ctrl_l.rbyte(1'b1, d);
        chk("large_rd", d, dl[m - 2]);
        i_ctrl_l.stop();
      end
    end
    bad = '{{PA, ~shl, 3'b001}, {PB, shl, 3'b101}, {PB, shl, 3'b011}, {PB, ~shl, 3'b001},
      {4'hE, shl, 3'b000}};
    for (int i = 0; i < 5; i++) begin
      i_ctrl_l.start();
      i_ctrl_l.wbyte(bad[i], a);
      chk("large_nack", 8'(a), 8'h00);
      i_ctrl_l.stop();
    end
    i_ctrl_l.start();
    i_ctrl_l.wbyte({PB, shl, 3'b000}, a);
    i_ctrl_l.wbyte({SEBUS_SN_WADR_PREFIX, 6'h00}, a);
    i_ctrl_l.start();
    i_ctrl_l.wbyte({PB, shl, 3'b001}, a);
    i_ctrl_l.rbyte(1'b1, d);
    chk("large_sn", d, sn_byte(0));
    i_ctrl_l.stop();
    end_of_test();
  end
endmodule
`default_nettype wire
